// ### include/ppl_pkg.sv
// constants, field layout and types for one phy port link/status/led block
// assumes a 50 MHz system clock and an apb master with 32-bit data
// ==========================================================================
package ppl_pkg;

  // ========================================================================
  // timing
  localparam int CLK_HZ      = 50_000_000;
  localparam int LINK_LOSS_MS = 100;
  localparam int NLP_MS       = 16;
  localparam int JAB_MS       = 50;
  localparam int UNJAB_MS     = 500;
  localparam int POST_MS      = 1000;
  localparam int STR0_MS      = 30;
  localparam int STR1_MS      = 60;
  localparam int STR2_MS      = 100;
  localparam int IDLE_WIN_MS  = 2;

  // ========================================================================
  // register map
  localparam logic [7:0]  OFF_CTRL = 8'h00;
  localparam logic [7:0]  OFF_STAT = 8'h04;
  localparam logic [7:0]  OFF_LED  = 8'h08;
  localparam int CB_FIBER   = 0;
  localparam int CB_PREPASS = 1;
  localparam int CB_CRSALN  = 2;
  localparam int CB_FORCE   = 3;
  localparam int CB_NOUNJAB = 4;
  localparam int CB_ALTNP   = 5;
  localparam int CB_ANEN    = 6;
  localparam int CB_LOOP    = 7;
  localparam int CB_DUPLEX  = 8;
  localparam logic [8:0]  CTRL_RST = 9'h040;
  localparam int SB_LINK = 0;
  localparam int SB_LLAT = 1;
  localparam int SB_FEF  = 2;
  localparam int SB_AND  = 3;
  localparam int SB_PAGE = 4;
  localparam int SB_BASE = 5;
  localparam int SB_JAB  = 6;
  localparam int SB_TXEN = 7;
  localparam int LED_MODE_LSB = 12;
  localparam int LED_STR_LSB  = 2;
  localparam logic [15:0] LED_RST = 16'h4210;

  // ========================================================================
  // codes
  localparam logic [7:0] PRE_BYTE  = 8'h55;
  localparam logic [7:0] SFD_BYTE  = 8'hd5;
  localparam logic [6:0] FEF_ONES  = 7'h54;
  localparam logic [1:0] FEF_REPS  = 2'h3;
  localparam logic [3:0] IDLE_RUN  = 4'hc;
  localparam logic [3:0] LM_SPEED  = 4'h0;
  localparam logic [3:0] LM_TX     = 4'h1;
  localparam logic [3:0] LM_RX     = 4'h2;
  localparam logic [3:0] LM_COL    = 4'h3;
  localparam logic [3:0] LM_LINK   = 4'h4;
  localparam logic [3:0] LM_DUPLEX = 4'h5;
  localparam logic [3:0] LM_ACT    = 4'h6;
  localparam logic [3:0] LM_LNKACT = 4'hd;
  localparam logic [1:0] STR_OFF   = 2'h3;

  typedef enum {RX_IDLE, RX_PRE, RX_DATA, RX_END} ppl_rx_e;

  function automatic logic [31:0] ms_cyc(input int ms);
    return 32'(ms * (CLK_HZ / 1000));
  endfunction

endpackage

// ### rtl/ppl_port.sv
// one port: 10 Mb/s receive framing, link test, jabber, fiber fault and
// idle link check, negotiation flags, three led drivers, apb registers
// assumes mii and symbol inputs on clk; line pins and straps asynchronous
`timescale 1ns/1ps

module ppl_port
  import ppl_pkg::*;
#(
  parameter int LINK_LOSS_T = LINK_LOSS_MS,
  parameter int NLP_T       = NLP_MS,
  parameter int JAB_T       = JAB_MS,
  parameter int UNJAB_T     = UNJAB_MS,
  parameter int POST_T      = POST_MS,
  parameter int STR0_T      = STR0_MS,
  parameter int STR1_T      = STR1_MS,
  parameter int STR2_T      = STR2_MS,
  parameter int IDLE_WIN_T  = IDLE_WIN_MS
) (
  // clock and reset
  input  wire logic        clk,
  input  wire logic        reset,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // mii toward the mac
  input  wire logic [3:0]  mii_txd,
  input  wire logic        mii_tx_en,
  input  wire logic        mii_col,
  output logic      [3:0]  mii_rxd,
  output logic             mii_rx_dv,
  output logic             mii_crs,
  output logic             mii_rx_stb,
  // 10 Mb/s line side, asynchronous
  input  wire logic        ln_rx_clk,
  input  wire logic        ln_rx_data,
  input  wire logic        ln_rx_act,
  input  wire logic        ln_link_pulse_in,
  output logic             ln_link_pulse_out,
  output logic             tx_enable,
  // 100 Mb/s fiber symbol side, on clk
  input  wire logic        fx_bit,
  input  wire logic        fx_bit_stb,
  input  wire logic        sym_stb,
  input  wire logic        sym_idle,
  // negotiation engine
  input  wire logic        an_complete_in,
  input  wire logic        an_start_in,
  input  wire logic        page_in,
  input  wire logic        page_base_in,
  output logic             an_restart,
  // led pins
  input  wire logic [2:0]  led_strap_in,
  output logic      [2:0]  led_out,
  output logic      [2:0]  led_oe
);

  localparam logic [31:0] LOSS_CYC  = ms_cyc(LINK_LOSS_T);
  localparam logic [31:0] NLP_CYC   = ms_cyc(NLP_T);
  localparam logic [31:0] JAB_CYC   = ms_cyc(JAB_T);
  localparam logic [31:0] UNJAB_CYC = ms_cyc(UNJAB_T);
  localparam logic [31:0] POST_CYC  = ms_cyc(POST_T);
  localparam logic [31:0] WIN_CYC   = ms_cyc(IDLE_WIN_T);

  // ========================================================================
  // helpers
  function automatic logic [31:0] str_cyc(input logic [1:0] sel);
    case (sel)
      2'h0:    return ms_cyc(STR0_T);
      2'h1:    return ms_cyc(STR1_T);
      default: return ms_cyc(STR2_T);
    endcase
  endfunction

  // st = {duplex, link, col, rx, tx, speed}
  function automatic logic led_cond(input logic [3:0] m, input logic [5:0] st);
    case (m)
      LM_SPEED:  return st[0];
      LM_TX:     return st[1];
      LM_RX:     return st[2];
      LM_COL:    return st[3];
      LM_LINK:   return st[4];
      LM_DUPLEX: return st[5];
      LM_ACT:    return st[1] | st[2];
      LM_LNKACT: return st[1] | st[2];
      default:   return 1'b0;
    endcase
  endfunction

  function automatic logic [3:0] pad_ones(input logic [3:0] n, input logic [1:0] k);
    logic [3:0] r;
    r = n;
    for (int i = 0; i < 4; i++) begin
      if (i >= int'(k)) begin
        r = {1'b1, r[3:1]};
      end
    end
    return r;
  endfunction

  // ========================================================================
  // synchronisers: stage a feeds only stage b, edges from b and c
  logic [6:0] sa_reg, sb_reg, sc_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      sa_reg <= 7'h00;
      sb_reg <= 7'h00;
      sc_reg <= 7'h00;
    end else begin
      sa_reg <= {led_strap_in, ln_link_pulse_in, ln_rx_act, ln_rx_data, ln_rx_clk};
      sb_reg <= sa_reg;
      sc_reg <= sb_reg;
    end
  end
  logic bit_stb, rx_bit, sof, eof, lp_edge;
  assign bit_stb = sb_reg[0] & ~sc_reg[0];
  assign rx_bit  = sb_reg[1];
  assign sof     = sb_reg[2] & ~sc_reg[2];
  assign eof     = ~sb_reg[2] & sc_reg[2];
  assign lp_edge = sb_reg[3] & ~sc_reg[3];

  // ========================================================================
  // registers
  logic [8:0]  ctrl_reg;
  logic [15:0] led_reg;
  logic [31:0] prd_reg;
  logic [7:0]  stat_vec;
  logic        hit_ctrl, hit_stat, hit_led, acc, rd_stat;
  logic        fiber, ten_meg_twisted_pair_mode, hundred_meg_fiber_mode, force_pass;
  assign hit_ctrl = paddr == OFF_CTRL;
  assign hit_stat = paddr == OFF_STAT;
  assign hit_led  = paddr == OFF_LED;
  assign acc      = psel & penable;
  assign rd_stat  = acc & ~pwrite & hit_stat;
  assign pready   = 1'b1;
  assign pslverr  = acc & ~(hit_ctrl | hit_stat | hit_led);
  assign prdata   = prd_reg;
  assign fiber    = ctrl_reg[CB_FIBER];
  assign hundred_meg_fiber_mode    = fiber;
  assign ten_meg_twisted_pair_mode = ~fiber;
  assign force_pass = ctrl_reg[CB_FORCE];

  always_ff @(posedge clk) begin
    if (reset) begin
      ctrl_reg <= CTRL_RST;
      led_reg  <= LED_RST;
    end else if (acc & pwrite) begin
      if (hit_ctrl) ctrl_reg <= pwdata[8:0];
      if (hit_led) led_reg <= pwdata[15:0];
    end
  end

  // read data latched in setup so clear-on-read drops only what was seen
  always_ff @(posedge clk) begin
    if (reset) begin
      prd_reg <= 32'h0000_0000;
    end else if (psel & ~penable) begin
      prd_reg <= hit_ctrl ? {23'h000000, ctrl_reg} :
                 hit_stat ? {24'h000000, stat_vec} :
                 hit_led  ? {16'h0000, led_reg} : 32'h0000_0000;
    end
  end

  // ========================================================================
  // 10 Mb/s receive framing toward the mii
  ppl_rx_e    rx_state;
  logic [7:0] sh_reg, sh_next;
  logic [3:0] nib_reg, nib_next, rxd_reg;
  logic [1:0] ncnt_reg;
  logic       nph_reg, pend_reg, rxdv_reg, crs_reg, rxstb_reg, jab_reg;
  assign sh_next  = {rx_bit, sh_reg[7:1]};
  assign nib_next = {rx_bit, nib_reg[3:1]};

  always_ff @(posedge clk) begin
    if (reset) begin
      rx_state  <= RX_IDLE;
      sh_reg    <= 8'h00;
      nib_reg   <= 4'h0;
      ncnt_reg  <= 2'h0;
      nph_reg   <= 1'b0;
      pend_reg  <= 1'b0;
      rxd_reg   <= 4'h0;
      rxdv_reg  <= 1'b0;
      crs_reg   <= 1'b0;
      rxstb_reg <= 1'b0;
    end else begin
      rxstb_reg <= 1'b0;
      pend_reg  <= 1'b0;
      if (ctrl_reg[CB_LOOP]) begin
        rx_state  <= RX_IDLE;
        rxd_reg   <= mii_txd;
        rxdv_reg  <= mii_tx_en & ~jab_reg;
        crs_reg   <= mii_tx_en & ~jab_reg;
        rxstb_reg <= mii_tx_en & ~jab_reg;
      end else if (pend_reg) begin
        rxd_reg   <= SFD_BYTE[7:4];
        rxstb_reg <= 1'b1;
      end else begin
        case (rx_state)
          RX_IDLE: begin
            rxdv_reg <= 1'b0;
            crs_reg  <= 1'b0;
            if (sof & ten_meg_twisted_pair_mode) begin
              rx_state <= RX_PRE;
              sh_reg   <= 8'h00;
            end
          end
          RX_PRE: begin
            if (eof) begin
              rx_state <= RX_IDLE;
            end else if (bit_stb) begin
              sh_reg <= sh_next;
              ncnt_reg <= 2'h0;
              nph_reg  <= 1'b0;
              if (ctrl_reg[CB_PREPASS] && sh_next == PRE_BYTE) begin
                rxdv_reg <= 1'b1;
                crs_reg  <= 1'b1;
                rx_state <= RX_DATA;
              end else if (!ctrl_reg[CB_PREPASS] && sh_next == SFD_BYTE) begin
                rxdv_reg  <= 1'b1;
                crs_reg   <= 1'b1;
                rxd_reg   <= SFD_BYTE[3:0];
                rxstb_reg <= 1'b1;
                pend_reg  <= 1'b1;
                rx_state  <= RX_DATA;
              end
            end
          end
          RX_DATA: begin
            if (eof) begin
              // partial first nibble goes out padded, partial second dropped
              if (ncnt_reg != 2'h0 && !nph_reg) begin
                rxd_reg   <= pad_ones(nib_reg, ncnt_reg);
                rxstb_reg <= 1'b1;
              end
              if (!ctrl_reg[CB_CRSALN]) crs_reg <= 1'b0;
              rx_state <= RX_END;
            end else if (bit_stb) begin
              nib_reg  <= nib_next;
              ncnt_reg <= ncnt_reg + 2'h1;
              if (ncnt_reg == 2'h3) begin
                rxd_reg   <= nib_next;
                rxstb_reg <= 1'b1;
                nph_reg   <= ~nph_reg;
              end
            end
          end
          RX_END: begin
            rxdv_reg <= 1'b0;
            crs_reg  <= 1'b0;
            rx_state <= RX_IDLE;
          end
          default: rx_state <= RX_IDLE;
        endcase
      end
    end
  end
  assign mii_rxd    = rxd_reg;
  assign mii_rx_dv  = rxdv_reg;
  assign mii_crs    = crs_reg;
  assign mii_rx_stb = rxstb_reg;

  // ========================================================================
  // 10 Mb/s link test and link pulse generation
  logic [31:0] lt_cnt, nlp_cnt;
  logic        link10_reg, nlp_reg;
  always_ff @(posedge clk) begin
    if (reset || !ten_meg_twisted_pair_mode) begin
      lt_cnt     <= 32'h0;
      link10_reg <= 1'b0;
    end else if (lp_edge || sof) begin
      lt_cnt <= 32'h0;
      if (lp_edge) link10_reg <= 1'b1;
    end else if (lt_cnt == LOSS_CYC - 32'h1) begin
      link10_reg <= 1'b0;
    end else begin
      lt_cnt <= lt_cnt + 32'h1;
    end
  end

  // pulses go out whatever the link state, but never over a frame
  always_ff @(posedge clk) begin
    if (reset || !ten_meg_twisted_pair_mode) begin
      nlp_cnt <= 32'h0;
      nlp_reg <= 1'b0;
    end else if (nlp_cnt == NLP_CYC - 32'h1) begin
      nlp_cnt <= 32'h0;
      nlp_reg <= ~mii_tx_en;
    end else begin
      nlp_cnt <= nlp_cnt + 32'h1;
      nlp_reg <= 1'b0;
    end
  end
  assign ln_link_pulse_out = nlp_reg;

  // ========================================================================
  // jabber
  logic [31:0] jcnt, ucnt;
  always_ff @(posedge clk) begin
    if (reset) begin
      jab_reg <= 1'b0;
      jcnt    <= 32'h0;
      ucnt    <= 32'h0;
    end else if (!jab_reg) begin
      ucnt <= 32'h0;
      if (!mii_tx_en || !ten_meg_twisted_pair_mode) begin
        jcnt <= 32'h0;
      end else if (jcnt == JAB_CYC - 32'h1) begin
        jab_reg <= 1'b1;
        jcnt    <= 32'h0;
      end else begin
        jcnt <= jcnt + 32'h1;
      end
    end else if (mii_tx_en || ctrl_reg[CB_NOUNJAB]) begin
      ucnt <= 32'h0;
    end else if (ucnt == UNJAB_CYC - 32'h1) begin
      jab_reg <= 1'b0;
      ucnt    <= 32'h0;
    end else begin
      ucnt <= ucnt + 32'h1;
    end
  end

  // ========================================================================
  // fiber far-end fault: 84 ones then a zero, three times over
  logic [6:0] ones_cnt;
  logic [1:0] rep_cnt;
  logic       fef_det, fef_flag;
  always_ff @(posedge clk) begin
    if (reset || !hundred_meg_fiber_mode) begin
      ones_cnt <= 7'h00;
      rep_cnt  <= 2'h0;
      fef_det  <= 1'b0;
    end else begin
      fef_det <= 1'b0;
      if (fx_bit_stb) begin
        if (fx_bit) begin
          if (ones_cnt != 7'h7f) ones_cnt <= ones_cnt + 7'h01;
        end else begin
          ones_cnt <= 7'h00;
          if (ones_cnt != FEF_ONES) begin
            rep_cnt <= 2'h0;
          end else if (rep_cnt == FEF_REPS - 2'h1) begin
            rep_cnt <= 2'h0;
            fef_det <= 1'b1;
          end else begin
            rep_cnt <= rep_cnt + 2'h1;
          end
        end
      end
    end
  end

  // ========================================================================
  // 100 Mb/s idle window link
  logic [31:0] win_cnt;
  logic [3:0]  irun;
  logic        met_reg, link100_reg;
  always_ff @(posedge clk) begin
    if (reset || !hundred_meg_fiber_mode) begin
      win_cnt     <= 32'h0;
      irun        <= 4'h0;
      met_reg     <= 1'b0;
      link100_reg <= 1'b0;
    end else begin
      if (win_cnt == WIN_CYC - 32'h1) begin
        win_cnt     <= 32'h0;
        link100_reg <= met_reg;
        met_reg     <= 1'b0;
      end else begin
        win_cnt <= win_cnt + 32'h1;
      end
      if (sym_stb) begin
        irun <= !sym_idle ? 4'h0 : (irun == IDLE_RUN) ? irun : irun + 4'h1;
        if (sym_idle && irun == IDLE_RUN - 4'h1) met_reg <= 1'b1;
      end
      if (fef_det && !force_pass) link100_reg <= 1'b0;
    end
  end

  // ========================================================================
  // status flags; a set in the clearing cycle wins
  logic link_up, link_prev, link_lat, an_done, page_rx, base_pg, txen_reg, anr_reg;
  assign link_up = hundred_meg_fiber_mode ? link100_reg : link10_reg;
  always_ff @(posedge clk) begin
    if (reset) begin
      link_prev <= 1'b0;
      link_lat  <= 1'b0;
      fef_flag  <= 1'b0;
      an_done   <= 1'b0;
      page_rx   <= 1'b0;
      base_pg   <= 1'b0;
      txen_reg  <= 1'b0;
      anr_reg   <= 1'b0;
    end else begin
      link_prev <= link_up;
      if (link_up && !link_prev) link_lat <= 1'b1;
      else if (!link_up && link_prev) link_lat <= 1'b0;
      else if (rd_stat) link_lat <= link_up;
      fef_flag <= (fef_flag & ~(rd_stat & prd_reg[SB_FEF])) | fef_det;
      an_done  <= (an_done & ~an_start_in) | an_complete_in;
      page_rx  <= (page_rx & ~(rd_stat & prd_reg[SB_PAGE])
                 & ~(ctrl_reg[CB_ALTNP] & an_start_in)) | page_in;
      base_pg  <= (base_pg & ~(rd_stat & prd_reg[SB_BASE]))
                 | (page_in & page_base_in);
      txen_reg <= ~jab_reg & (force_pass | link_up);
      anr_reg  <= link_prev & ~link_up & ctrl_reg[CB_ANEN] & ~force_pass;
    end
  end
  assign stat_vec   = {txen_reg, jab_reg, base_pg, page_rx, an_done, fef_flag, link_lat, link_up};
  assign tx_enable  = txen_reg;
  assign an_restart = anr_reg;

  // ========================================================================
  // leds: strap capture, lamp test, stretch
  logic [1:0]  strap_cnt;
  logic        strap_done, post_on;
  logic [2:0]  led_pol;
  logic [31:0] post_cnt;
  logic [5:0]  led_st;
  assign led_st = {ctrl_reg[CB_DUPLEX], link_up, mii_col, crs_reg, mii_tx_en, fiber};

  // pins stay undriven until the synchronised strap level has been taken
  always_ff @(posedge clk) begin
    if (reset) begin
      strap_cnt  <= 2'h0;
      strap_done <= 1'b0;
      led_pol    <= 3'h0;
    end else if (!strap_done) begin
      strap_cnt <= strap_cnt + 2'h1;
      if (strap_cnt == 2'h2) begin
        led_pol    <= sb_reg[6:4];
        strap_done <= 1'b1;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      post_on  <= 1'b1;
      post_cnt <= 32'h0;
    end else if (post_on) begin
      if (post_cnt == POST_CYC - 32'h1) post_on <= 1'b0;
      post_cnt <= post_cnt + 32'h1;
    end
  end

  for (genvar i = 0; i < 3; i++) begin : g_led
    logic [3:0]  mode;
    logic [1:0]  ssel;
    logic [31:0] tmr;
    logic        evt, prev, lit, blink, on, out_reg, oe_reg;
    assign mode = led_reg[LED_MODE_LSB - 4 * i +: 4];
    assign ssel = led_reg[LED_STR_LSB +: 2];
    assign evt  = led_cond(mode, led_st);
    // lit also covers the cycle in which a rearmed edge is pending
    assign lit  = (ssel == STR_OFF) ? evt : ((tmr != 32'h0) | (evt & ~prev));
    assign on   = post_on | ((mode == LM_LNKACT) ? (link_up & (~lit | blink)) : lit);
    always_ff @(posedge clk) begin
      if (reset) begin
        tmr   <= 32'h0;
        prev  <= 1'b0;
        blink <= 1'b0;
      end else begin
        prev <= evt;
        if (evt && !prev && ssel != STR_OFF) begin
          tmr <= str_cyc(ssel);
        end else if (tmr == 32'h1) begin
          tmr   <= 32'h0;
          prev  <= 1'b0;
          blink <= ~blink;
        end else if (tmr != 32'h0) begin
          tmr <= tmr - 32'h1;
        end
      end
    end
    // high strap means led to supply: sink it; low strap: source it
    always_ff @(posedge clk) begin
      if (reset) begin
        out_reg <= 1'b0;
        oe_reg  <= 1'b0;
      end else begin
        out_reg <= ~led_pol[i];
        oe_reg  <= strap_done & on;
      end
    end
    assign led_out[i] = out_reg;
    assign led_oe[i]  = oe_reg;
  end

endmodule

// ### tb/ppl_port_props.sv
// checker: apb answers, receive framing and start-up of one port
// assumes it is bound onto ppl_port and sees only its ports
`timescale 1ns/1ps
// ====
// checker
module ppl_port_props (
  // clock and reset
  input wire logic        clk,
  input wire logic        reset,
  // apb
  input wire logic        psel,
  input wire logic        penable,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  // port outputs
  input wire logic        mii_rx_dv,
  input wire logic        mii_crs,
  input wire logic        tx_enable,
  input wire logic        an_restart,
  input wire logic        ln_link_pulse_out,
  input wire logic [2:0]  led_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);
  wire acc = psel && penable;
  wire map = paddr inside {8'h00, 8'h04, 8'h08};
  a_zero_wait: assert property (acc |-> pready) else $error("apb stalled");
  a_unmapped_err: assert property (acc && !map |-> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  a_mapped_ok: assert property (acc && map |-> !pslverr) else $error("mapped access refused");
  a_nlp_pulse: assert property (ln_link_pulse_out |=> !ln_link_pulse_out)
    else $error("link pulse too long");
  a_restart_pulse: assert property (an_restart |=> !an_restart)
    else $error("restart pulse too long");
  a_dv_with_crs: assert property ($rose(mii_rx_dv) |-> mii_crs)
    else $error("data valid without carrier");
  a_reset_quiet: assert property ($fell(reset) |-> !mii_rx_dv && !tx_enable && led_oe == 3'h0)
    else $error("outputs busy after reset");
  a_lamp_start: assert property ($fell(reset) |-> ##[2:5] led_oe == 3'h7)
    else $error("lamp test missing");
  c_frame: cover property ($rose(mii_rx_dv));
  c_refused: cover property (acc && pslverr);
  c_lamp_off: cover property ($fell(led_oe[0]));
endmodule

// ### tb/ppl_mac_model.sv
// mac model: on request sends preamble, sfd nibble and four data nibbles
// assumes mii transmit signals move just after clk rising edges
`timescale 1ns/1ps
// ====
// mac model
module ppl_mac_model (
  // clock and request
  input  wire logic       clk,
  input  wire logic       go,
  // mii transmit
  output logic      [3:0] txd,
  output logic            tx_en,
  output logic            col
);
  int n = 0;
  initial begin
    txd = 4'h0;
    tx_en = 1'b0;
    col = 1'b0;
  end
  // idle nibbles keep toggling so a stale value cannot pass for an echo
  always @(posedge clk) begin
    if (go || (n > 0 && n < 21)) begin
      tx_en <= 1'b1;
      txd <= n < 16 ? 4'h5 : n == 16 ? 4'hd : 4'(n - 16);
      n <= n + 1;
    end else begin
      tx_en <= 1'b0;
      txd <= ~txd;
      n <= 0;
    end
  end
endmodule

// ### tb/phy_port_link_status_led_test.sv
// bench: register map, 10 Mb/s receive, loopback, status flags, leds
// assumes ppl_pkg, ppl_port, the checker and the mac model are compiled
`timescale 1ns/1ps
// ====
// bench
module phy_port_link_status_led_test import ppl_pkg::*;;
  logic clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0, pready, pslverr, err, go = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] mii_txd, mii_rxd, q[$];
  logic mii_tx_en, mii_col, mii_rx_dv, mii_crs, mii_rx_stb, ln_link_pulse_out, tx_enable;
  logic ln_rx_clk = 0, ln_rx_data = 0, ln_rx_act = 0, ln_link_pulse_in = 0, an_restart;
  logic fx_bit = 0, fx_bit_stb = 0, sym_stb = 0, sym_idle = 0, an_complete_in = 0;
  logic an_start_in = 0, page_in = 0, page_base_in = 0;
  logic [2:0] led_strap_in = 3'h7, led_out, led_oe;
  int err_total = 0, samples_checked = 0, npl = 0, nar = 0;
  typedef struct {logic w; logic [7:0] a; logic [31:0] d, x; logic e;} ppl_row_s;
  ppl_row_s rows[6] = '{'{0, 8'h00, 0, 32'h040, 0}, '{0, 8'h08, 0, 32'h4210, 0},
    '{1, 8'h0c, 32'hffff_ffff, 0, 1}, '{0, 8'h0c, 0, 0, 1},
    '{1, 8'h08, 32'hd218, 0, 0}, '{0, 8'h08, 0, 32'hd218, 0}};
  initial forever #10 clk = ~clk;
  ppl_port #(.POST_T(1), .NLP_T(1), .LINK_LOSS_T(1)) dut (.clk, .reset, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .mii_txd,
    .mii_tx_en, .mii_col, .mii_rxd,
    .mii_rx_dv, .mii_crs, .mii_rx_stb, .ln_rx_clk, .ln_rx_data, .ln_rx_act,
    .ln_link_pulse_in, .ln_link_pulse_out, .tx_enable, .fx_bit, .fx_bit_stb, .sym_stb,
    .sym_idle, .an_complete_in, .an_start_in, .page_in, .page_base_in, .an_restart,
    .led_strap_in, .led_out, .led_oe);
  ppl_mac_model mac (.clk, .go, .txd(mii_txd), .tx_en(mii_tx_en), .col(mii_col));
  always @(posedge clk) begin
    if (mii_rx_stb === 1'b1)
      q.push_back(mii_rxd);
    if (ln_link_pulse_out === 1'b1)
      npl++;
    if (an_restart === 1'b1)
      nar++;
  end
  task automatic chk(input logic [31:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("[FAIL] %0t seen %h want %h", $time, seen, exp);
    end
  endtask
  // ====
  // drivers
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // no wait-state count assumed: only the watchdog ends a stalled access
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask
  // line clock stands still between frames, data then shows the inverse
  task automatic lbits(input logic [7:0] b, input int n);
    for (int i = 0; i < n; i++) begin
      ln_rx_data <= b[i];
      ln_rx_clk <= 1'b0;
      repeat (4) @(posedge clk);
      ln_rx_clk <= 1'b1;
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic frame(input int drib);
    q.delete();
    ln_rx_act <= 1'b1;
    repeat (7) lbits(8'h55, 8);
    lbits(8'hd5, 8);
    lbits(8'ha3, 8);
    lbits(8'h75, drib);
    ln_rx_act <= 1'b0;
    ln_rx_clk <= 1'b0;
    ln_rx_data <= ~ln_rx_data;
    repeat (20) @(posedge clk);
  endtask
  task automatic conclude;
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // ====
  // tests
  initial begin
    repeat (2) @(posedge clk);
    reset <= 1'b0;
    repeat (6) @(posedge clk);
    chk(led_oe, 3'h7);
    chk(led_out, 3'h0);
    foreach (rows[i]) begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      chk(err, rows[i].e);
      if (!rows[i].w) chk(rd, rows[i].x);
    end
    $display("registers done");
    apb(1'b1, 8'h00, 32'h040);
    frame(3);
    chk({q.size(), q[0], q[1], q[2], q[3], q[4]}, 52'h5_5d3ad);
    $display("strip done");
    apb(1'b1, 8'h00, 32'h042);
    frame(5);
    chk({q.size() > 10, q[0], q[$-1], q[$]}, 13'h15a5);
    $display("pass done");
    apb(1'b1, 8'h00, 32'h0c0);
    q.delete();
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    repeat (30) @(posedge clk);
    chk({q.size(), q[15], q[16], q[20]}, 44'h15_5d4);
    $display("loopback done");
    apb(1'b1, 8'h00, 32'h041);
    fx_bit_stb <= 1'b1;
    repeat (3) begin
      fx_bit <= 1'b1;
      repeat (84) @(posedge clk);
      fx_bit <= 1'b0;
      @(posedge clk);
    end
    fx_bit_stb <= 1'b0;
    {an_complete_in, page_in, page_base_in} <= 3'h7;
    @(posedge clk);
    {an_complete_in, page_in, page_base_in} <= 3'h0;
    apb(1'b0, 8'h04, 32'h0);
    chk(rd[5:2], 4'hf);
    apb(1'b0, 8'h04, 32'h0);
    chk(rd[5:2], 4'h2);
    $display("flags done");
    apb(1'b1, 8'h00, 32'h040);
    ln_link_pulse_in <= 1'b1;
    repeat (8) @(posedge clk);
    ln_link_pulse_in <= 1'b0;
    chk(tx_enable, 1'b1);
    // one pulse only: the link must lapse and ask for a new negotiation
    repeat (52000) @(posedge clk);
    chk({npl > 0, led_oe[0]}, 2'h2);
    chk(nar, 1);
    $display("leds done");
    apb(1'b1, 8'h00, 32'h048);
    repeat (2) @(posedge clk);
    chk(tx_enable, 1'b1);
    $display("force done");
    reset <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    repeat (6) @(posedge clk);
    chk({tx_enable, led_oe}, 4'h7);
    apb(1'b0, 8'h00, 32'h0);
    chk(rd, 32'h040);
    $display("reset done");
    conclude();
  end
  // the full run takes about 1.1 ms
  initial begin
    #1_500_000;
    err_total++;
    conclude();
  end
endmodule
bind ppl_port ppl_port_props props (.clk, .reset, .psel, .penable, .paddr, .prdata,
  .pready, .pslverr, .mii_rx_dv, .mii_crs, .tx_enable, .an_restart, .ln_link_pulse_out,
  .led_oe);
